// [bench/gjkff_top_sva.sv]
/* port checker of the gated J-K element
   bound onto gjkff_top; sees its ports only */
module gjkff_top_sva #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire gjkff_pkg::gjkff_pins_t pins,
    input wire logic q_out,
    input wire logic q_n_out,
    input wire logic clk_edge_out,
    input wire logic lockout_out,
    input wire logic force_conflict_out
);
    localparam int D = SYNC_STAGES + 1;
    wire lo = !pins.elem_clk;
    wire pr = lo & !pins.preset_n & pins.clear_n;
    wire cl = lo & pins.preset_n & !pins.clear_n;
    wire bo = lo & !pins.preset_n & !pins.clear_n;
    wire fr = lo & !(pins.preset_n & pins.clear_n);
    wire j = &pins.set_gates;
    wire k = &pins.reset_gates;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    jk_update_a: assert property (
        clk_edge_out |-> q_out == ($past(j, D) & !$past(q_out)
            | !$past(k, D) & $past(q_out))) else $error("bad update");
    q_hold_a: assert property (
        $changed(q_out) |-> clk_edge_out || $past(fr, D))
        else $error("q moved without cause");
    edge_cause_a: assert property (
        clk_edge_out |-> $past(pins.elem_clk, D)
            && !$past(pins.elem_clk, D + 1)) else $error("stray edge");
    edge_pulse_a: assert property (
        clk_edge_out |=> !clk_edge_out) else $error("long edge pulse");
    preset_force_a: assert property (
        $past(pr, D) |-> q_out && !q_n_out) else $error("preset lost");
    clear_force_a: assert property (
        $past(cl, D) |-> !q_out && q_n_out) else $error("clear lost");
    lock_track_a: assert property (
        lockout_out == $past(pins.elem_clk, D))
        else $error("lockout out of step");
    both_low_a: assert property (
        $past(bo, D) |-> !q_out && !q_n_out && force_conflict_out)
        else $error("double force wrong");
    compl_out_a: assert property (
        !force_conflict_out && !$past(force_conflict_out)
            |-> q_n_out == !q_out) else $error("outputs not inverse");
    cover property (clk_edge_out && q_out);
    cover property (clk_edge_out && !q_out);
    cover property (force_conflict_out);
endmodule
bind gjkff_top gjkff_top_sva #(.SYNC_STAGES(SYNC_STAGES)) u_sva (
    .core_clk(core_clk), .nrst(nrst), .pins(pins), .q_out(q_out),
    .q_n_out(q_n_out), .clk_edge_out(clk_edge_out),
    .lockout_out(lockout_out), .force_conflict_out(force_conflict_out));

// [bench/test_gjkff_top.sv]
/* bench of the gated J-K element
   drives the pins itself; all waits are fixed counts */
module test_gjkff_top;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
        num_errors++; $display("mismatch %0t got %b want %b", \
        $time, a, e); end end
    logic core_clk = 0;
    logic nrst = 0;
    gjkff_pkg::gjkff_pins_t pins = gjkff_pkg::PINS_IDLE;
    logic q_out, q_n_out, clk_edge_out, lockout_out, force_conflict_out;
    logic exp_q = 0;
    int num_errors = 0;
    int n_compared = 0;
    always #12.5 core_clk = ~core_clk;
    gjkff_top uut (.core_clk(core_clk), .nrst(nrst), .pins(pins),
        .q_out(q_out), .q_n_out(q_n_out), .clk_edge_out(clk_edge_out),
        .lockout_out(lockout_out), .force_conflict_out(force_conflict_out));
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task end_of_test;
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one element clock; gates flipped while high must not count
    task t_jk(input logic [2:0] s, input logic [2:0] r);
        pins.set_gates = s;
        pins.reset_gates = r;
        pins.elem_clk = 0;
        cyc(4);
        pins.elem_clk = 1;
        exp_q = &s & !exp_q | !(&r) & exp_q;
        cyc(3);
        `CHK({q_out, clk_edge_out}, {exp_q, 1'h1})
        cyc(1);
        `CHK({clk_edge_out, lockout_out}, 2'h1)
        pins.set_gates = 3'h7;
        pins.reset_gates = 3'h7;
        cyc(4);
        `CHK(q_out, exp_q)
        `CHK(q_n_out, !exp_q)
    endtask
    task t_force(input logic p, input logic c, input logic eq, input logic en);
        pins.elem_clk = 0;
        pins.preset_n = p;
        pins.clear_n = c;
        cyc(4);
        `CHK({q_out, q_n_out}, {eq, en})
        `CHK({force_conflict_out, lockout_out}, {~(p | c), 1'h0})
        pins.preset_n = 1;
        pins.clear_n = 1;
        cyc(5);
        exp_q = eq;
    endtask
    // preset while the element clock is high is ignored
    task t_gated;
        pins.set_gates = 3'h0;
        pins.reset_gates = 3'h0;
        cyc(4);
        pins.elem_clk = 1;
        cyc(4);
        pins.preset_n = 0;
        cyc(4);
        `CHK(q_out, exp_q)
        pins.preset_n = 1;
        cyc(4);
    endtask
    initial begin
        cyc(12);
        nrst = 1;
        cyc(1);
        `CHK({q_out, q_n_out}, 2'h1)
        `CHK(lockout_out, 1'h1)
        for (int i = 0; i < 64; i++)
            t_jk(i[5:3], i[2:0]);
        t_force(1'b0, 1'b1, 1'b1, 1'b0);
        t_force(1'b1, 1'b0, 1'b0, 1'b1);
        t_force(1'b0, 1'b1, 1'b1, 1'b0);
        t_force(1'b0, 1'b0, 1'b0, 1'b0);
        t_gated;
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        end_of_test;
    end
endmodule

// [src/gjkff_pkg.sv]
/*
 * Shared types and constants of the gated J-K storage element.
 * Assumes every pin of the element is asynchronous to core_clk
 * and is resynchronised before any logic reads it.
 */
// Summary of operation
// - Stored state and both outputs change only on a rising element clock or under preset or clear; q_n also recovers after a double force ends.
// - After a rising element clock, J and K are ignored until the next one.
// - Effective J is the AND of three set gates, K of three reset gates.
// - At the edge J=K=0 holds, J only sets, K only clears, both toggle.
// - Preset low with clear high forces the true output to one at once.
// - Clear low with preset high forces the true output to zero at once.
// - Preset and clear both low drive both outputs to zero.
// - Preset and clear act only while the element clock is low.
// - True and complementary outputs, inverse unless both forces are low.
package gjkff_pkg;

    localparam int SYNC_STAGES = 2;
    localparam int GATE_INPUTS = 3;

    typedef struct packed {
        logic elem_clk;
        logic preset_n;
        logic clear_n;
        logic [GATE_INPUTS-1:0] set_gates;
        logic [GATE_INPUTS-1:0] reset_gates;
    } gjkff_pins_t;

    localparam int PINS_W = $bits(gjkff_pins_t);

    // clock high (locked), both forces released, gates low
    localparam gjkff_pins_t PINS_IDLE = 9'h1C0;

    localparam logic Q_RESET = 1'h0;
    localparam logic Q_N_RESET = 1'h1;

    typedef enum logic {
        GJKFF_ARMED,
        GJKFF_LOCKED
    } gjkff_state_t;

    typedef struct packed {
        logic q;
        logic q_n;
    } gjkff_outs_t;

endpackage

// [src/gjkff_sync.sv]
/*
 * Multi-stage synchroniser for a group of pin levels.
 * Assumes the inputs are levels from outside the core_clk domain;
 * only the last stage may be read by other logic.
 */
module gjkff_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg [STAGES];
    logic [WIDTH-1:0] stage_next [STAGES];

    always_comb begin
        stage_next[0] = async_in;
        for (int i = 1; i < STAGES; i++) begin
            stage_next[i] = stage_reg[i-1];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= RESET_VAL;
            end
        end else begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= stage_next[i];
            end
        end
    end

    assign sync_out = stage_reg[STAGES-1];

endmodule

// [src/gjkff_top.sv]
/*
 * Gated edge-triggered J-K storage element, sampled on core_clk.
 * Assumes core_clk runs well faster than the element clock pin, and
 * ignores preset and clear while that pin is high.
 */
module gjkff_top #(
    parameter int SYNC_STAGES = gjkff_pkg::SYNC_STAGES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire gjkff_pkg::gjkff_pins_t pins,
    output logic q_out,
    output logic q_n_out,
    output logic clk_edge_out,
    output logic lockout_out,
    output logic force_conflict_out
);

    gjkff_pkg::gjkff_pins_t pins_sync;

    gjkff_sync #(
        .WIDTH(gjkff_pkg::PINS_W),
        .STAGES(SYNC_STAGES),
        .RESET_VAL(gjkff_pkg::PINS_IDLE)
    ) u_pin_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .async_in(pins),
        .sync_out(pins_sync)
    );

    function automatic logic gate_and(
        input logic [gjkff_pkg::GATE_INPUTS-1:0] g
    );
        return &g;
    endfunction

    function automatic logic jk_result(
        input logic j,
        input logic k,
        input logic q
    );
        logic r;
        r = q;
        unique case ({j, k})
            2'h0: r = q;
            2'h1: r = 1'h0;
            2'h2: r = 1'h1;
            2'h3: r = ~q;
        endcase
        return r;
    endfunction

    logic clk_high;
    logic j_eff;
    logic k_eff;
    logic preset_act;
    logic clear_act;

    gjkff_pkg::gjkff_state_t state_reg;
    gjkff_pkg::gjkff_state_t state_next;
    logic edge_reg;
    logic edge_next;
    gjkff_pkg::gjkff_outs_t outs_reg;
    gjkff_pkg::gjkff_outs_t outs_next;
    logic conflict_reg;
    logic conflict_next;

    assign clk_high = pins_sync.elem_clk;
    assign j_eff = gate_and(pins_sync.set_gates);
    assign k_eff = gate_and(pins_sync.reset_gates);

    assign preset_act = ~pins_sync.preset_n & ~clk_high;
    assign clear_act = ~pins_sync.clear_n & ~clk_high;

    // edge recognition and lockout
    always_comb begin
        state_next = state_reg;
        edge_next = 1'h0;
        unique case (state_reg)
            gjkff_pkg::GJKFF_ARMED: begin
                if (clk_high) begin
                    state_next = gjkff_pkg::GJKFF_LOCKED;
                    edge_next = 1'h1;
                end
            end
            gjkff_pkg::GJKFF_LOCKED: begin
                if (!clk_high) begin
                    state_next = gjkff_pkg::GJKFF_ARMED;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= gjkff_pkg::GJKFF_LOCKED;
            edge_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            edge_reg <= edge_next;
        end
    end

    // stored state and outputs
    always_comb begin
        outs_next = outs_reg;
        conflict_next = 1'h0;
        if (preset_act && clear_act) begin
            outs_next.q = 1'h0;
            outs_next.q_n = 1'h0;
            conflict_next = 1'h1;
        end else if (preset_act) begin
            outs_next.q = 1'h1;
            outs_next.q_n = 1'h0;
        end else if (clear_act) begin
            outs_next.q = 1'h0;
            outs_next.q_n = 1'h1;
        end else if (state_reg == gjkff_pkg::GJKFF_ARMED && clk_high) begin
            outs_next.q = jk_result(j_eff, k_eff, outs_reg.q);
            outs_next.q_n = ~jk_result(j_eff, k_eff, outs_reg.q);
        end else begin
            // complement restored after a double force
            outs_next.q_n = ~outs_reg.q;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            outs_reg <= '{q: gjkff_pkg::Q_RESET, q_n: gjkff_pkg::Q_N_RESET};
            conflict_reg <= 1'h0;
        end else begin
            outs_reg <= outs_next;
            conflict_reg <= conflict_next;
        end
    end

    assign q_out = outs_reg.q;
    assign q_n_out = outs_reg.q_n;
    assign clk_edge_out = edge_reg;
    assign lockout_out = (state_reg == gjkff_pkg::GJKFF_LOCKED);
    assign force_conflict_out = conflict_reg;

endmodule
